// [logic/imr_master_rx.sv]
/*
 * imr_master_rx: two-wire bus master with byte reception, start, stop,
 * repeated start, address transmit and acknowledge sequence.
 * assumes: command pulses and buffer strobes come from logic on ref_clk_i;
 * the bus engine runs on link_clk_i; open-drain lines are resolved outside,
 * with pull-ups, from the *_oe_o enables.
 */
// Functional notes
// - lines are only pulled low or released
// - open with start, address, direction bit
// - acknowledge is data line held low
// - data changes while clock low, except start/stop
// - stop: data rises while clock high
// - new start instead of stop keeps bus
// - receive request ignored unless port idle
// - baud rollovers toggle clock, shift data in
// - eighth fall: clear request, load buffer, flag
// - buffer-full set on load, cleared by read
// - byte while buffer full sets overflow flag
// - buffer write mid-transfer sets collision, ignored
// - start request makes start, then event flag
// - buffer write sends address byte at once
// - sampled slave acknowledge stored as status
// - event flag after ninth address clock
// - acknowledge sequence sends selected value, flags
// - receive and acknowledge repeat per byte
`timescale 1ns/1ps
module imr_master_rx
    import imr_pkg::*;
#(
    parameter logic [IMR_BRG_W-1:0] BRG_RELOAD = IMR_BRG_DEFAULT
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  link_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  start_condition_request_i,
    input  wire logic                  stop_request_i,
    input  wire logic                  receive_byte_request_i,
    input  wire logic                  ack_sequence_request_i,
    input  wire logic                  ack_value_select_i,
    input  wire logic                  buf_write_i,
    input  wire logic [IMR_BYTE_W-1:0] buf_wdata_i,
    input  wire logic                  buf_read_i,
    input  wire logic                  event_clear_i,
    input  wire logic                  overflow_clear_i,
    input  wire logic                  collision_clear_i,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       scl_o,
    output logic                       scl_oe_o,
    output logic                       sda_o,
    output logic                       sda_oe_o,
    output logic [IMR_BYTE_W-1:0]      buf_rdata_o,
    output logic                       buffer_full_flag_o,
    output logic                       receive_overflow_flag_o,
    output logic                       write_collision_flag_o,
    output logic                       port_event_flag_o,
    output logic                       ack_received_status_o,
    output logic                       receive_byte_request_o,
    output logic                       idle_o
);

    // register side, ref_clk_i
    imr_cmd_t              cmd_q;
    logic                  busy_q;
    logic                  req_tgl_q;
    logic                  ackval_q;
    logic [IMR_BYTE_W-1:0] tx_q;
    logic [IMR_BYTE_W-1:0] holding_q;
    logic                  full_q;
    logic                  ov_q;
    logic                  coll_q;
    logic                  evt_q;
    logic                  ack_seen_q;
    logic                  idle_q;
    logic                  rxreq_q;
    logic                  done_s1_q;
    logic                  done_s2_q;
    logic                  done_s3_q;
    logic                  done_p;
    logic                  launch;
    logic                  rx_done;

    // bus side, link_clk_i
    imr_lstate_t           lst_q;
    logic                  req_s1_q;
    logic                  req_s2_q;
    logic                  req_s3_q;
    logic                  ce_s1_q;
    logic                  ce_s2_q;
    logic                  scl_s1_q;
    logic                  scl_s2_q;
    logic                  sda_s1_q;
    logic                  sda_s2_q;
    logic [IMR_BRG_W-1:0]  brg_q;
    logic [1:0]            ph_q;
    logic [3:0]            bit_q;
    logic [3:0]            nbits;
    logic [IMR_BYTE_W-1:0] sh_q;
    logic                  ack_in_q;
    logic                  scl_oe_q;
    logic                  sda_oe_q;
    logic                  done_tgl_q;
    logic                  tick;
    logic                  stretch;
    logic                  drive_low;
    logic                  last_bit;

    assign done_p  = done_s2_q ^ done_s3_q;
    assign rx_done = done_p && (cmd_q == IMR_CMD_RX);

    // one command at a time; start outranks the rest
    always_comb begin
        launch = 1'b0;
        if (!busy_q) begin
            launch = start_condition_request_i | stop_request_i |
                     ack_sequence_request_i | receive_byte_request_i | buf_write_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else if (ce_i) begin
            done_s1_q <= done_tgl_q;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    // command word is held stable while busy, so the engine reads it safely
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q     <= IMR_CMD_START;
            busy_q    <= 1'b0;
            idle_q    <= 1'b1;
            req_tgl_q <= 1'b0;
            ackval_q  <= 1'b0;
            tx_q      <= IMR_BYTE_RST;
        end else if (ce_i) begin
            if (launch) begin
                busy_q    <= 1'b1;
                idle_q    <= 1'b0;
                req_tgl_q <= ~req_tgl_q;
                if (start_condition_request_i) begin
                    cmd_q <= IMR_CMD_START;
                end else if (stop_request_i) begin
                    cmd_q <= IMR_CMD_STOP;
                end else if (ack_sequence_request_i) begin
                    cmd_q    <= IMR_CMD_ACK;
                    ackval_q <= ack_value_select_i;
                end else if (receive_byte_request_i) begin
                    cmd_q <= IMR_CMD_RX;
                end else begin
                    cmd_q <= IMR_CMD_TX;
                    tx_q  <= buf_wdata_i;
                end
            end else if (done_p) begin
                busy_q <= 1'b0;
                idle_q <= 1'b1;
            end
        end
    end

    // holding buffer: software write when idle, received byte on completion
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            holding_q <= IMR_BYTE_RST;
        end else if (ce_i) begin
            if (rx_done) begin
                holding_q <= sh_q;
            end else if (buf_write_i && !busy_q && !start_condition_request_i &&
                         !stop_request_i && !ack_sequence_request_i &&
                         !receive_byte_request_i) begin
                holding_q <= buf_wdata_i;
            end
        end
    end

    // set wins over clear for every flag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            full_q <= IMR_FLAG_RST;
            ov_q   <= IMR_FLAG_RST;
        end else if (ce_i) begin
            if (rx_done) begin
                full_q <= 1'b1;
            end else if (buf_read_i) begin
                full_q <= 1'b0;
            end
            if (rx_done && full_q && !buf_read_i) begin
                ov_q <= 1'b1;
            end else if (overflow_clear_i) begin
                ov_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            coll_q <= IMR_FLAG_RST;
        end else if (ce_i) begin
            if (buf_write_i && busy_q) begin
                coll_q <= 1'b1;
            end else if (collision_clear_i) begin
                coll_q <= 1'b0;
            end
        end
    end

    // hardware only sets the event flag; software clears it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_q <= IMR_FLAG_RST;
        end else if (ce_i) begin
            if (done_p) begin
                evt_q <= 1'b1;
            end else if (event_clear_i) begin
                evt_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_seen_q <= IMR_FLAG_RST;
            rxreq_q    <= IMR_FLAG_RST;
        end else if (ce_i) begin
            if (done_p && cmd_q == IMR_CMD_TX) begin
                ack_seen_q <= ack_in_q;
            end
            if (launch && receive_byte_request_i && !start_condition_request_i &&
                !stop_request_i && !ack_sequence_request_i) begin
                rxreq_q <= 1'b1;
            end else if (rx_done) begin
                rxreq_q <= 1'b0;
            end
        end
    end

    assign buf_rdata_o             = holding_q;
    assign buffer_full_flag_o      = full_q;
    assign receive_overflow_flag_o = ov_q;
    assign write_collision_flag_o  = coll_q;
    assign port_event_flag_o       = evt_q;
    assign ack_received_status_o   = ack_seen_q;
    assign receive_byte_request_o  = rxreq_q;
    assign idle_o                  = idle_q;

    // bus engine on link_clk_i
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ce_s1_q  <= 1'b0;
            ce_s2_q  <= 1'b0;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            ce_s1_q  <= ce_i;
            ce_s2_q  <= ce_s1_q;
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
        end
    end

    // a released clock line held low by a slave stalls the baud count
    assign stretch  = !scl_oe_q && !scl_s2_q;
    assign tick     = (lst_q == IMR_L_RUN) && (brg_q == '0) && !stretch;
    assign last_bit = (bit_q == nbits - IMR_ONE_STEP);

    always_comb begin
        case (cmd_q)
            IMR_CMD_TX: nbits = IMR_TX_BITS;
            IMR_CMD_RX: nbits = IMR_RX_BITS;
            default:    nbits = IMR_ONE_STEP;
        endcase
    end

    // value put on the data line in the setup phase, clock low
    always_comb begin
        case (cmd_q)
            IMR_CMD_TX:  drive_low = (bit_q != IMR_ACK_SLOT) && !sh_q[IMR_BYTE_W-1];
            IMR_CMD_ACK: drive_low = !ackval_q;
            default:     drive_low = 1'b0;
        endcase
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            brg_q <= IMR_BRG_DEFAULT;
        end else if (ce_s2_q) begin
            if (lst_q != IMR_L_RUN || brg_q == '0) begin
                brg_q <= BRG_RELOAD;
            end else if (!stretch) begin
                brg_q <= brg_q - IMR_BRG_W'(1);
            end
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lst_q      <= IMR_L_IDLE;
            req_s3_q   <= 1'b0;
            done_tgl_q <= 1'b0;
            ph_q       <= IMR_PH_SETUP;
            bit_q      <= 4'h0;
        end else if (ce_s2_q) begin
            req_s3_q <= req_s2_q;
            case (lst_q)
                IMR_L_IDLE: begin
                    if (req_s2_q ^ req_s3_q) begin
                        lst_q <= IMR_L_RUN;
                        ph_q  <= IMR_PH_SETUP;
                        bit_q <= 4'h0;
                    end
                end
                IMR_L_RUN: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == IMR_PH_FALL) begin
                            bit_q <= bit_q + 4'h1;
                            if (last_bit) begin
                                lst_q <= IMR_L_DONE;
                            end
                        end
                    end
                end
                IMR_L_DONE: begin
                    // baud count stops; clock stays where the command left it
                    done_tgl_q <= ~done_tgl_q;
                    lst_q      <= IMR_L_IDLE;
                end
                default: lst_q <= IMR_L_IDLE;
            endcase
        end
    end

    // line drivers: only ever pull low or release
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (ce_s2_q && tick) begin
            if (cmd_q == IMR_CMD_START) begin
                case (ph_q)
                    IMR_PH_SETUP:  sda_oe_q <= 1'b0;
                    IMR_PH_RISE:   scl_oe_q <= 1'b0;
                    IMR_PH_SAMPLE: sda_oe_q <= 1'b1;
                    default:       scl_oe_q <= 1'b1;
                endcase
            end else if (cmd_q == IMR_CMD_STOP) begin
                case (ph_q)
                    IMR_PH_SETUP:  sda_oe_q <= 1'b1;
                    IMR_PH_RISE:   scl_oe_q <= 1'b0;
                    IMR_PH_SAMPLE: sda_oe_q <= 1'b0;
                    default:       scl_oe_q <= 1'b0;
                endcase
            end else begin
                case (ph_q)
                    IMR_PH_SETUP:  sda_oe_q <= drive_low;
                    IMR_PH_RISE:   scl_oe_q <= 1'b0;
                    IMR_PH_SAMPLE: scl_oe_q <= 1'b0;
                    default:       scl_oe_q <= 1'b1;
                endcase
            end
        end
    end

    // shift register: loaded at accept, shifted on the bit phases
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_q     <= IMR_BYTE_RST;
            ack_in_q <= 1'b1;
        end else if (ce_s2_q) begin
            if (lst_q == IMR_L_IDLE && (req_s2_q ^ req_s3_q) && cmd_q == IMR_CMD_TX) begin
                sh_q <= tx_q;
            end else if (tick && ph_q == IMR_PH_SAMPLE) begin
                if (cmd_q == IMR_CMD_RX) begin
                    sh_q <= {sh_q[IMR_BYTE_W-2:0], sda_s2_q};
                end else if (cmd_q == IMR_CMD_TX && bit_q == IMR_ACK_SLOT) begin
                    ack_in_q <= sda_s2_q;
                end
            end else if (tick && ph_q == IMR_PH_FALL && cmd_q == IMR_CMD_TX) begin
                sh_q <= {sh_q[IMR_BYTE_W-2:0], 1'b0};
            end
        end
    end

    assign scl_o    = IMR_LINE_LOW;
    assign sda_o    = IMR_LINE_LOW;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;

endmodule : imr_master_rx

// [logic/imr_pkg.sv]
/*
 * imr_pkg: constants and types for the two-wire bus master receiver.
 * assumes: shared by the single design module; no other users.
 */
package imr_pkg;

    // command carried from the register side to the bus engine
    typedef enum logic [2:0] {
        IMR_CMD_START,
        IMR_CMD_STOP,
        IMR_CMD_TX,
        IMR_CMD_RX,
        IMR_CMD_ACK
    } imr_cmd_t;

    // bus engine state
    typedef enum logic [1:0] {
        IMR_L_IDLE,
        IMR_L_RUN,
        IMR_L_DONE
    } imr_lstate_t;

    localparam int          IMR_BYTE_W      = 8;
    localparam int          IMR_BRG_W       = 8;
    localparam logic [7:0]  IMR_BRG_DEFAULT = 8'h04;
    localparam logic [3:0]  IMR_TX_BITS     = 4'h9;
    localparam logic [3:0]  IMR_RX_BITS     = 4'h8;
    localparam logic [3:0]  IMR_ONE_STEP    = 4'h1;
    localparam logic [3:0]  IMR_ACK_SLOT    = 4'h8;
    localparam logic [1:0]  IMR_PH_SETUP    = 2'h0;
    localparam logic [1:0]  IMR_PH_RISE     = 2'h1;
    localparam logic [1:0]  IMR_PH_SAMPLE   = 2'h2;
    localparam logic [1:0]  IMR_PH_FALL     = 2'h3;
    localparam logic [7:0]  IMR_BYTE_RST    = 8'h00;
    localparam logic        IMR_FLAG_RST    = 1'b0;
    localparam logic        IMR_LINE_LOW    = 1'b0;

endpackage : imr_pkg

// [tb/imr_master_rx_sva.sv]
/* imr_master_rx_sva: port-level checks of the master receiver.
   assumes: bound to imr_master_rx; checks live in the ref_clk_i domain. */
`timescale 1ns/1ps
module imr_master_rx_sva (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_condition_request_i,
    input wire logic stop_request_i,
    input wire logic receive_byte_request_i,
    input wire logic ack_sequence_request_i,
    input wire logic buf_write_i,
    input wire logic buf_read_i,
    input wire logic event_clear_i,
    input wire logic scl_o,
    input wire logic sda_o,
    input wire logic buffer_full_flag_o,
    input wire logic receive_overflow_flag_o,
    input wire logic write_collision_flag_o,
    input wire logic port_event_flag_o,
    input wire logic receive_byte_request_o,
    input wire logic idle_o
);
    localparam int RX_MAX = 1000;
    logic hi_pri;
    // requests that win over a receive request in the same cycle
    assign hi_pri = start_condition_request_i | stop_request_i | ack_sequence_request_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    rx_ignore_a: assert property (
        receive_byte_request_i && !idle_o && !receive_byte_request_o |=> !receive_byte_request_o)
        else $error("busy receive request taken");
    rx_take_a: assert property (
        receive_byte_request_i && idle_o && ce_i && !hi_pri |=> receive_byte_request_o && !idle_o)
        else $error("idle receive request lost");
    rx_done_a: assert property (
        $fell(receive_byte_request_o) |-> buffer_full_flag_o && port_event_flag_o && idle_o)
        else $error("receive end without flags");
    rx_bound_a: assert property (
        $rose(receive_byte_request_o) |-> ##[1:RX_MAX] !receive_byte_request_o)
        else $error("receive never ends");
    wr_collide_a: assert property (
        buf_write_i && ce_i && !idle_o |=> write_collision_flag_o)
        else $error("busy write without collision");
    full_clear_a: assert property (
        buf_read_i && ce_i && !receive_byte_request_o |=> !buffer_full_flag_o)
        else $error("read leaves buffer full");
    ovf_set_a: assert property (
        $fell(receive_byte_request_o) && $past(buffer_full_flag_o) && !$past(buf_read_i)
        |-> receive_overflow_flag_o)
        else $error("overflow not flagged");
    evt_hold_a: assert property (
        port_event_flag_o && !event_clear_i |=> port_event_flag_o)
        else $error("event flag dropped");
    od_low_a: assert property (!scl_o && !sda_o)
        else $error("line driven high");

    cover property ($fell(receive_byte_request_o));
    cover property ($rose(write_collision_flag_o));
    cover property ($rose(receive_overflow_flag_o));
endmodule : imr_master_rx_sva

bind imr_master_rx imr_master_rx_sva imr_master_rx_sva_i (.ref_clk_i, .rst_i, .ce_i,
    .start_condition_request_i, .stop_request_i, .receive_byte_request_i,
    .ack_sequence_request_i, .buf_write_i, .buf_read_i, .event_clear_i, .scl_o, .sda_o,
    .buffer_full_flag_o, .receive_overflow_flag_o, .write_collision_flag_o,
    .port_event_flag_o, .receive_byte_request_o, .idle_o);

// [tb/imr_slave_model.sv]
/* imr_slave_model: behavioural slave on the two-wire bus.
   assumes: lines resolved with pull-ups by the bench; no address compare. */
`timescale 1ns/1ps
module imr_slave_model (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic       ack_addr_i,
    input  wire logic       slow_i,
    output logic            scl_oe_o,
    output logic            sda_oe_o
);
    logic [7:0] sr;
    logic       act, rd, mack;
    int         cnt;
    initial begin
        {scl_oe_o, sda_oe_o, act, rd, mack} = '0;
        sr = 8'h00;
        cnt = 0;
    end
    always @(negedge sda_i) begin
        if (scl_i) begin
            act = 1'b1;
            rd = 1'b0;
            cnt = -1;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) act = 1'b0;
    end
    always @(posedge scl_i) begin
        if (act && !rd && cnt < 8) sr = {sr[6:0], sda_i};
        if (act && rd && cnt == 8) mack = !sda_i;
    end
    // data only moves on a clock fall, so it is stable while the clock is high
    always @(negedge scl_i) begin
        if (act) begin
            cnt = cnt + 1;
            if (!rd && cnt == 8) sda_oe_o = ack_addr_i;
            else if (!rd && cnt == 9) begin
                rd = sr[0];
                cnt = 0;
                sda_oe_o = sr[0] & ~tx_byte_i[7];
            end else if (rd && cnt < 8) sda_oe_o = ~tx_byte_i[7 - cnt];
            else if (rd && cnt == 8) sda_oe_o = 1'b0;
            else if (rd && cnt == 9) begin
                cnt = 0;
                act = mack;
                sda_oe_o = mack & ~tx_byte_i[7];
            end
        end
    end
    // slow mode stretches each low phase; the master must wait for the line
    always @(negedge scl_i) begin
        if (act && slow_i) begin
            scl_oe_o = 1'b1;
            #200;
            scl_oe_o = 1'b0;
        end
    end
endmodule : imr_slave_model

// [tb/imr_master_rx_tb.sv]
/* imr_master_rx_tb: directed command sequences for the master receiver.
   assumes: imr_slave_model on the bus; pull-ups on both lines. */
`timescale 1ns/1ps
module imr_master_rx_tb;
    logic       ref_clk, link_clk, rst, ce, ackv, ack_addr, slow;
    logic [8:0] req;
    logic [7:0] wdata, tx, rdata;
    logic       scl_o, scl_oe, sda_o, sda_oe, bfull, ovf, coll, evt, acks, rxq, idl;
    logic       s_scl_oe, s_sda_oe;
    wire        scl_w, sda_w;
    int         fail_count, n_tests;
    assign scl_w = ~((scl_oe & ~scl_o) | s_scl_oe);
    assign sda_w = ~((sda_oe & ~sda_o) | s_sda_oe);

    imr_master_rx #(.BRG_RELOAD(8'h01)) imr_master_rx_i (
        .ref_clk_i(ref_clk), .link_clk_i(link_clk), .rst_i(rst), .ce_i(ce),
        .start_condition_request_i(req[0]), .stop_request_i(req[1]),
        .receive_byte_request_i(req[2]), .ack_sequence_request_i(req[3]),
        .ack_value_select_i(ackv), .buf_write_i(req[4]), .buf_wdata_i(wdata),
        .buf_read_i(req[5]), .event_clear_i(req[6]), .overflow_clear_i(req[7]),
        .collision_clear_i(req[8]), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
        .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe), .buf_rdata_o(rdata),
        .buffer_full_flag_o(bfull), .receive_overflow_flag_o(ovf),
        .write_collision_flag_o(coll), .port_event_flag_o(evt),
        .ack_received_status_o(acks), .receive_byte_request_o(rxq), .idle_o(idl));
    imr_slave_model imr_slave_model_i (.scl_i(scl_w), .sda_i(sda_w), .tx_byte_i(tx),
        .ack_addr_i(ack_addr), .slow_i(slow), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #15 link_clk = ~link_clk;
    end

    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    // one-cycle strobe on request line k
    task automatic pulse(input int k);
        @(posedge ref_clk);
        #1;
        req = 9'h001 << k;
        @(posedge ref_clk);
        #1;
        req = 9'h000;
    endtask : pulse
    task automatic wait_evt();
        int n;
        n = 0;
        while (evt !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk1("event", 1'b1, evt);
        chk1("idle", 1'b1, idl);
        pulse(6);
    endtask : wait_evt
    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #300000;
        fail_count++;
        wrap_up();
    end

    initial begin
        {req, wdata, ackv, slow} = '0;
        rst = 1'b1;
        ce = 1'b1;
        ack_addr = 1'b1;
        tx = 8'h96;
        fail_count = 0;
        n_tests = 0;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk1("reset sda_oe", 1'b0, sda_oe);
        chk1("reset full", 1'b0, bfull);
        pulse(0);
        wait_evt();
        chk1("sda start", 1'b0, sda_w);
        wdata = 8'hA1;
        pulse(4);
        wdata = 8'h5A;
        pulse(4);
        pulse(2);
        chk1("collision", 1'b1, coll);
        chk8("buffer", 8'hA1, rdata);
        chk1("rx pending", 1'b0, rxq);
        wait_evt();
        chk1("ack status", 1'b0, acks);
        chk8("address", 8'hA1, imr_slave_model_i.sr);
        pulse(8);
        chk1("collision clr", 1'b0, coll);
        pulse(2);
        chk1("rx pending", 1'b1, rxq);
        wait_evt();
        chk8("byte", 8'h96, rdata);
        chk1("full", 1'b1, bfull);
        chk1("rx pending", 1'b0, rxq);
        chk1("scl held", 1'b0, scl_w);
        tx = 8'h3C;
        pulse(3);
        wait_evt();
        chk1("master ack", 1'b1, imr_slave_model_i.mack);
        slow = 1'b1;
        pulse(2);
        wait_evt();
        chk8("byte", 8'h3C, rdata);
        chk1("overflow", 1'b1, ovf);
        pulse(5);
        chk1("full", 1'b0, bfull);
        pulse(7);
        chk1("overflow clr", 1'b0, ovf);
        ackv = 1'b1;
        pulse(3);
        wait_evt();
        chk1("master ack", 1'b0, imr_slave_model_i.mack);
        pulse(1);
        wait_evt();
        chk1("scl stop", 1'b1, scl_w);
        chk1("sda stop", 1'b1, sda_w);
        slow = 1'b0;
        ack_addr = 1'b0;
        pulse(0);
        wait_evt();
        wdata = 8'h90;
        pulse(4);
        wait_evt();
        chk1("nack status", 1'b1, acks);
        pulse(0);
        wait_evt();
        chk1("sda restart", 1'b0, sda_w);
        chk1("restart seen", 1'b1, imr_slave_model_i.cnt == 0);
        // a frozen port must not take a request, even while idle
        ce = 1'b0;
        pulse(2);
        chk1("frozen rx", 1'b0, rxq);
        chk1("frozen idle", 1'b1, idl);
        ce = 1'b1;
        pulse(1);
        wait_evt();
        wrap_up();
    end
endmodule : imr_master_rx_tb
